/* File: char_fifo.sv */
// Character buffer that works as a deep FIFO or a one-word holding register.
`timescale 1ns/1ps
module char_fifo #(
	parameter int unsigned W = 8
) (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic srst,
	// Buffer side.
	fifo_if.store q
);
	import uart_pkg::*;

	logic [W-1:0] mem_r [FIFO_DEPTH];
	logic [PTR_W-1:0] wp_r;
	logic [PTR_W-1:0] rp_r;
	logic [CNT_W-1:0] cnt_r;
	logic do_push;
	logic do_pop;

	// Full limit follows the mode; a push into a full buffer is dropped.
	assign q.full = q.one_deep ? (cnt_r != '0) : (cnt_r == CNT_W'(FIFO_DEPTH));
	assign q.empty = (cnt_r == '0);
	assign q.rdata = mem_r[rp_r];
	assign do_push = q.push && !q.full;
	assign do_pop = q.pop && !q.empty;

	// Storage write.
	always_ff @(posedge clk_sys) begin
		if (do_push) begin
			mem_r[wp_r] <= q.wdata;
		end
	end

	// Pointers and fill count.
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
		end else begin
			if (do_push) begin
				wp_r <= wp_r + 1'b1;
			end
			if (do_pop) begin
				rp_r <= rp_r + 1'b1;
			end
			if (do_push && !do_pop) begin
				cnt_r <= cnt_r + 1'b1;
			end else if (do_pop && !do_push) begin
				cnt_r <= cnt_r - 1'b1;
			end
		end
	end
endmodule : char_fifo

/* File: fifo_if.sv */
// Carrier between the port logic and one of its character buffers.
`timescale 1ns/1ps
interface fifo_if #(parameter int unsigned W = 8) ();
	logic push;
	logic [W-1:0] wdata;
	logic pop;
	logic one_deep;
	logic [W-1:0] rdata;
	logic full;
	logic empty;
	modport owner (output push, output wdata, output pop, output one_deep, input rdata, input full, input empty);
	modport store (input push, input wdata, input pop, input one_deep, output rdata, output full, output empty);
endinterface : fifo_if

/* File: remote_serial.sv */
// Model of the remote serial transceiver at the far end of the two lines.
`timescale 1ns/1ps
module remote_serial #(
	parameter int BIT_CYC = 32
) (
	// Time base.
	input wire logic clk_sys,
	// Serial lines.
	input wire logic tx_line,
	output logic rx_line
);
	// The line rests at the marking level between frames.
	initial rx_line = 1'b1;
	// Sends start, eight data bits, parity when asked, and a stop bit of the given level.
	task automatic send(input logic [7:0] d, input logic pen, input logic par, input logic stop);
		logic [10:0] f;
		int n;
		f = pen ? {stop, par, d, 1'b0} : {1'b1, stop, d, 1'b0};
		n = pen ? 11 : 10;
		for (int i = 0; i < n; i++) begin
			@(posedge clk_sys);
			rx_line <= f[i];
			repeat (BIT_CYC - 1) @(posedge clk_sys);
		end
		@(posedge clk_sys);
		rx_line <= 1'b1;
	endtask : send
	// Holds the line low for a break of n cycles.
	task automatic hold_low(input int n);
		@(posedge clk_sys);
		rx_line <= 1'b0;
		repeat (n) @(posedge clk_sys);
		rx_line <= 1'b1;
	endtask : hold_low
	// Takes a frame from the line: eight data bits, least first, and the bit after them.
	task automatic get(output logic [7:0] d, output logic nb);
		int w;
		w = 0;
		while (tx_line !== 1'b0 && w < 20000) begin
			@(posedge clk_sys);
			w++;
		end
		repeat (BIT_CYC / 2) @(posedge clk_sys);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT_CYC) @(posedge clk_sys);
			d[i] = tx_line;
		end
		repeat (BIT_CYC) @(posedge clk_sys);
		nb = tx_line;
	endtask : get
endmodule : remote_serial

/* File: uart_data_status_path.sv */
// Serial port data path, receive status and flag registers on a peripheral bus slave.
`timescale 1ns/1ps

// Overview of operation
// - Data write queues byte or holds it
// - Frame: start, data, optional parity, stops
// - Received byte plus four status bits stored
// - Without buffering, one holding word receives
// - Data read: byte, framing, parity, break, overrun
// - Overrun marks arrival into a full buffer
// - Break: input low through a whole frame
// - Break stores one zero character, then waits
// - Parity mismatch and low stop bit flagged
// - Error bits travel with their own character; overrun with the next one
// - Any status write clears all error bits
// - Status bits: overrun, break, parity, framing
// - Status latches on data read; overrun immediate
// - Overrun leaves buffer intact, drops new character
// - Disable finishes the character in progress
// - Flags after reset: both empty set, rest clear
// - Empty and full flags follow selected mode
// - Busy from queued data until stop sent
// - Ring flag is inverted ring input
// - Buffer enable bit selects FIFO mode
// - Transmit buffer: 32 entries, 8 bits
// - Receive buffer: 32 entries, 12 bits
// - Even parity select chooses odd or even
module uart_data_status_path (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic srst,
	// Peripheral bus slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Serial line and modem input.
	input wire logic rx_line,
	output logic tx_line,
	input wire logic phone_call_line_n
);
	import uart_pkg::*;

	// Parity bit for a character under the current line settings.
	function automatic logic parity_bit(input logic [7:0] d, input logic [1:0] wlen, input logic even_parity_sel,
		input logic stick_parity_sel);
		logic [7:0] mask;
		logic p;
		mask = 8'hFF >> (2'd3 - wlen);
		p = ^(d & mask);
		if (stick_parity_sel) begin
			parity_bit = ~even_parity_sel;
		end else begin
			parity_bit = even_parity_sel ? p : ~p;
		end
	endfunction : parity_bit

	fifo_if #(.W(TX_W)) txq ();
	fifo_if #(.W(RX_W)) rxq ();

	logic [31:0] prdata_r;
	logic pready_r;
	logic pslverr_r;
	logic tx_line_r;
	logic [7:0] line_ctrl_r;
	logic [15:0] ser_ctrl_r;
	logic [15:0] baud_int_r;
	logic [5:0] baud_frac_r;
	logic [7:0] lp_div_r;
	logic [5:0] level_sel_r;
	logic [10:0] irq_mask_r;
	logic [2:0] dma_ctrl_r;
	logic [3:0] rx_status_r;
	logic [15:0] baud_cnt_r;
	logic baud_tick_r;
	logic [2:0] rx_sync_r;
	logic [2:0] ri_sync_r;
	logic rx_lvl_r;
	logic ri_lvl_r;
	tx_state_t tx_state_r;
	logic [3:0] tx_tick_r;
	logic [2:0] tx_bit_r;
	logic tx_stop2_r;
	logic [7:0] tx_sh_r;
	logic tx_pop_r;
	rx_state_t rx_state_r;
	logic [3:0] rx_tick_r;
	logic [2:0] rx_bit_r;
	logic [7:0] rx_sh_r;
	logic rx_pe_r;
	logic rx_all_low_r;
	logic rx_push_r;
	logic [RX_W-1:0] rx_wdata_r;
	logic rx_ovr_evt_r;
	logic ovr_pending_r;
	logic setup;
	logic access;
	logic wr_data;
	logic rd_data;
	logic wr_status;
	logic fifo_enable_bit;
	logic [2:0] last_bit;
	logic port_on;
	logic busy;
	logic [15:0] flags;

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign tx_line = tx_line_r;

	// Bus phases: setup captures the answer, access completes it one cycle later.
	assign setup = psel && !penable;
	assign access = psel && penable && pready_r;
	assign wr_data = access && pwrite && (paddr == OFF_DATA);
	assign rd_data = access && !pwrite && (paddr == OFF_DATA);
	assign wr_status = access && pwrite && (paddr == OFF_RX_STATUS);

	// Mode and frame shape taken from the line control register.
	assign fifo_enable_bit = line_ctrl_r[LCR_FEN];
	assign last_bit = {1'b1, line_ctrl_r[LCR_WLEN +: 2]};
	assign port_on = ser_ctrl_r[CR_UARTEN];
	assign busy = !txq.empty || (tx_state_r != TX_IDLE);

	// Buffer connections; one-deep holding registers when buffering is off.
	assign txq.one_deep = !fifo_enable_bit;
	assign rxq.one_deep = !fifo_enable_bit;
	assign txq.push = wr_data;
	assign txq.wdata = pwdata[7:0];
	assign txq.pop = tx_pop_r;
	assign rxq.push = rx_push_r;
	assign rxq.wdata = rx_wdata_r;
	assign rxq.pop = rd_data;

	// Flag word: ring, tx empty, rx full, tx full, rx empty, busy.
	assign flags = {7'h00, ri_lvl_r, txq.empty, rxq.full, txq.full, rxq.empty, busy, 3'h0};

	char_fifo #(.W(TX_W)) u_tx_fifo (
		.clk_sys(clk_sys),
		.srst(srst),
		.q(txq.store)
	);

	char_fifo #(.W(RX_W)) u_rx_fifo (
		.clk_sys(clk_sys),
		.srst(srst),
		.q(rxq.store)
	);

	// Bus answer: read data, ready and error are captured in the setup cycle.
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			prdata_r <= 32'h00000000;
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
		end else if (setup) begin
			pready_r <= 1'b1;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h00000000;
			unique case (paddr)
				OFF_DATA: prdata_r <= {20'h00000, rxq.rdata};
				OFF_RX_STATUS: prdata_r <= {28'h0000000, rx_status_r};
				OFF_FLAGS: prdata_r <= {16'h0000, flags};
				OFF_LP_DIV: prdata_r <= {24'h000000, lp_div_r};
				OFF_BAUD_INT: prdata_r <= {16'h0000, baud_int_r};
				OFF_BAUD_FRAC: prdata_r <= {26'h0, baud_frac_r};
				OFF_LINE_CTRL: prdata_r <= {24'h000000, line_ctrl_r};
				OFF_SER_CTRL: prdata_r <= {16'h0000, ser_ctrl_r};
				OFF_LEVEL_SEL: prdata_r <= {26'h0, level_sel_r};
				OFF_IRQ_MASK: prdata_r <= {21'h0, irq_mask_r};
				OFF_RAW_IRQ, OFF_MASKED_IRQ, OFF_IRQ_CLEAR: prdata_r <= 32'h00000000;
				OFF_DMA_CTRL: prdata_r <= {29'h0, dma_ctrl_r};
				default: pslverr_r <= 1'b1;
			endcase
		end else begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
		end
	end

	// Control and configuration registers written by software.
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			line_ctrl_r <= LINE_CTRL_RST;
			ser_ctrl_r <= SER_CTRL_RST;
			baud_int_r <= BAUD_INT_RST;
			baud_frac_r <= 6'h00;
			lp_div_r <= 8'h00;
			level_sel_r <= LEVEL_SEL_RST;
			irq_mask_r <= 11'h000;
			dma_ctrl_r <= 3'h0;
		end else if (access && pwrite) begin
			unique case (paddr)
				OFF_LINE_CTRL: line_ctrl_r <= pwdata[7:0];
				OFF_SER_CTRL: ser_ctrl_r <= pwdata[15:0];
				OFF_BAUD_INT: baud_int_r <= pwdata[15:0];
				OFF_BAUD_FRAC: baud_frac_r <= pwdata[5:0];
				OFF_LP_DIV: lp_div_r <= pwdata[7:0];
				OFF_LEVEL_SEL: level_sel_r <= pwdata[5:0];
				OFF_IRQ_MASK: irq_mask_r <= pwdata[10:0];
				OFF_DMA_CTRL: dma_ctrl_r <= pwdata[2:0];
				default: ;
			endcase
		end
	end

	// Receive status: character errors latch on a data read, overrun at once.
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			rx_status_r <= 4'h0;
		end else begin
			if (wr_status) begin
				rx_status_r <= 4'h0;
			end
			if (rd_data && !rxq.empty) begin
				rx_status_r[2:0] <= {rxq.rdata[ENT_BE], rxq.rdata[ENT_PE], rxq.rdata[ENT_FE]};
			end
			if (rx_ovr_evt_r) begin
				rx_status_r[3] <= 1'b1;
			end
		end
	end

	// Sixteen-times baud enable from the integer divisor; zero stops it.
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			baud_cnt_r <= 16'h0000;
			baud_tick_r <= 1'b0;
		end else if (baud_int_r == 16'h0000) begin
			baud_cnt_r <= 16'h0000;
			baud_tick_r <= 1'b0;
		end else if (baud_cnt_r >= baud_int_r - 16'h0001) begin
			baud_cnt_r <= 16'h0000;
			baud_tick_r <= 1'b1;
		end else begin
			baud_cnt_r <= baud_cnt_r + 16'h0001;
			baud_tick_r <= 1'b0;
		end
	end

	// Pin synchronisers; a level counts once the second and third stages agree.
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			rx_sync_r <= 3'h7;
			ri_sync_r <= 3'h7;
			rx_lvl_r <= 1'b1;
			ri_lvl_r <= 1'b0;
		end else begin
			rx_sync_r <= {rx_sync_r[1:0], rx_line};
			ri_sync_r <= {ri_sync_r[1:0], phone_call_line_n};
			if (rx_sync_r[1] == rx_sync_r[2]) begin
				rx_lvl_r <= rx_sync_r[2];
			end
			if (ri_sync_r[1] == ri_sync_r[2]) begin
				ri_lvl_r <= ~ri_sync_r[2];
			end
		end
	end

	// Transmit sequencer; enable is only looked at between characters.
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			tx_state_r <= TX_IDLE;
			tx_tick_r <= 4'h0;
			tx_bit_r <= 3'h0;
			tx_stop2_r <= 1'b0;
			tx_sh_r <= 8'h00;
			tx_pop_r <= 1'b0;
			tx_line_r <= 1'b1;
		end else begin
			tx_pop_r <= 1'b0;
			unique case (tx_state_r)
				TX_IDLE: begin
					tx_line_r <= !line_ctrl_r[LCR_BRK];
					if (baud_tick_r && port_on && ser_ctrl_r[CR_TXE] && !txq.empty && !tx_pop_r) begin
						tx_sh_r <= txq.rdata;
						tx_pop_r <= 1'b1;
						tx_tick_r <= 4'h0;
						tx_line_r <= 1'b0;
						tx_state_r <= TX_START;
					end
				end
				TX_START, TX_DATA, TX_PAR, TX_STOP: begin
					if (baud_tick_r) begin
						tx_tick_r <= tx_tick_r + 4'h1;
						if (tx_tick_r == TICK_LAST) begin
							unique case (tx_state_r)
								TX_START: begin
									tx_bit_r <= 3'h0;
									tx_line_r <= tx_sh_r[0];
									tx_state_r <= TX_DATA;
								end
								TX_DATA: begin
									tx_bit_r <= tx_bit_r + 3'h1;
									tx_line_r <= tx_sh_r[3'(tx_bit_r + 3'h1)];
									if (tx_bit_r == last_bit) begin
										tx_stop2_r <= line_ctrl_r[LCR_STP2];
										if (line_ctrl_r[LCR_PEN]) begin
											tx_line_r <= parity_bit(tx_sh_r, line_ctrl_r[LCR_WLEN +: 2],
												line_ctrl_r[LCR_EPS], line_ctrl_r[LCR_SPS]);
											tx_state_r <= TX_PAR;
										end else begin
											tx_line_r <= 1'b1;
											tx_state_r <= TX_STOP;
										end
									end
								end
								TX_PAR: begin
									tx_line_r <= 1'b1;
									tx_state_r <= TX_STOP;
								end
								default: begin
									if (tx_stop2_r) begin
										tx_stop2_r <= 1'b0;
									end else begin
										tx_state_r <= TX_IDLE;
									end
								end
							endcase
						end
					end
				end
			endcase
		end
	end

	// Receive sequencer with parity, framing, break and overrun detection.
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			rx_state_r <= RX_IDLE;
			rx_tick_r <= 4'h0;
			rx_bit_r <= 3'h0;
			rx_sh_r <= 8'h00;
			rx_pe_r <= 1'b0;
			rx_all_low_r <= 1'b0;
			rx_push_r <= 1'b0;
			rx_wdata_r <= 12'h000;
			rx_ovr_evt_r <= 1'b0;
			ovr_pending_r <= 1'b0;
		end else begin
			rx_push_r <= 1'b0;
			rx_ovr_evt_r <= 1'b0;
			if (baud_tick_r) begin
				rx_tick_r <= rx_tick_r + 4'h1;
				unique case (rx_state_r)
					RX_IDLE: begin
						rx_tick_r <= 4'h0;
						if (port_on && ser_ctrl_r[CR_RXE] && !rx_lvl_r) begin
							rx_state_r <= RX_START;
						end
					end
					RX_START: begin
						if (rx_tick_r == TICK_MID) begin
							rx_tick_r <= 4'h0;
							rx_bit_r <= 3'h0;
							rx_sh_r <= 8'h00;
							rx_pe_r <= 1'b0;
							rx_all_low_r <= 1'b1;
							rx_state_r <= rx_lvl_r ? RX_IDLE : RX_DATA;
						end
					end
					RX_DATA: begin
						if (rx_tick_r == TICK_LAST) begin
							rx_sh_r[rx_bit_r] <= rx_lvl_r;
							rx_all_low_r <= rx_all_low_r && !rx_lvl_r;
							rx_bit_r <= rx_bit_r + 3'h1;
							if (rx_bit_r == last_bit) begin
								rx_state_r <= line_ctrl_r[LCR_PEN] ? RX_PAR : RX_STOP;
							end
						end
					end
					RX_PAR: begin
						if (rx_tick_r == TICK_LAST) begin
							rx_pe_r <= rx_lvl_r != parity_bit(rx_sh_r, line_ctrl_r[LCR_WLEN +: 2],
								line_ctrl_r[LCR_EPS], line_ctrl_r[LCR_SPS]);
							rx_all_low_r <= rx_all_low_r && !rx_lvl_r;
							rx_state_r <= RX_STOP;
						end
					end
					RX_STOP: begin
						if (rx_tick_r == TICK_LAST) begin
							// Low through start, data, parity and stop is a break.
							if (rxq.full) begin
								rx_ovr_evt_r <= 1'b1;
								ovr_pending_r <= 1'b1;
							end else begin
								rx_push_r <= 1'b1;
								ovr_pending_r <= 1'b0;
								rx_wdata_r <= {ovr_pending_r, rx_all_low_r && !rx_lvl_r,
									rx_pe_r && !(rx_all_low_r && !rx_lvl_r), !rx_lvl_r,
									(rx_all_low_r && !rx_lvl_r) ? 8'h00 : rx_sh_r};
							end
							// A low stop bit must rise again first, so it is not taken for a new start.
							rx_state_r <= !rx_lvl_r ? RX_BRK_WAIT : RX_IDLE;
						end
					end
					RX_BRK_WAIT: begin
						rx_tick_r <= 4'h0;
						if (rx_lvl_r) begin
							rx_state_r <= RX_IDLE;
						end
					end
					default: rx_state_r <= RX_IDLE;
				endcase
			end
		end
	end
endmodule : uart_data_status_path

/* File: uart_data_status_path_props.sv */
// Checker of the bus answers, flag fields and status fields of the serial port.
`timescale 1ns/1ps
module uart_data_status_path_props (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic srst,
	// Peripheral bus.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Serial line and modem input.
	input wire logic rx_line,
	input wire logic tx_line,
	input wire logic phone_call_line_n
);
	import uart_pkg::*;
	logic rd_acc;
	logic wr_acc;
	logic ring_prev_r;
	logic [3:0] ring_cnt_r;
	logic fresh_r;
	logic hold_ok_r;
	logic [2:0] hold_val_r;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (srst);
	// Completed reads and writes.
	assign rd_acc = psel && penable && pready && !pwrite;
	assign wr_acc = psel && penable && pready && pwrite;
	// Counts how long the ring input has stood still, so the synchroniser has caught up.
	always_ff @(posedge clk_sys) begin
		ring_prev_r <= phone_call_line_n;
		if (srst || phone_call_line_n != ring_prev_r) begin
			ring_cnt_r <= 4'h0;
		end else if (ring_cnt_r != 4'hF) begin
			ring_cnt_r <= ring_cnt_r + 4'h1;
		end
	end
	// Marks the quiet time after reset, before any character was written or heard.
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			fresh_r <= 1'b1;
		end else if ((wr_acc && paddr == OFF_DATA) || !rx_line) begin
			fresh_r <= 1'b0;
		end
	end
	// Keeps the last status read until a data read or a clear may change it.
	always_ff @(posedge clk_sys) begin
		if (srst || (rd_acc && paddr == OFF_DATA) || (wr_acc && paddr == OFF_RX_STATUS)) begin
			hold_ok_r <= 1'b0;
		end else if (rd_acc && paddr == OFF_RX_STATUS) begin
			hold_ok_r <= 1'b1;
			hold_val_r <= prdata[2:0];
		end
	end
	ring_flag_a: assert property (rd_acc && paddr == OFF_FLAGS && ring_cnt_r >= 4'h8
		|-> prdata[8] == !phone_call_line_n && prdata[31:9] == 23'h0) else $error("Ring flag wrong.");
	reset_flags_a: assert property (rd_acc && paddr == OFF_FLAGS && fresh_r
		|-> prdata[7:3] == 5'h12) else $error("Flags after reset wrong.");
	flag_pairs_a: assert property (rd_acc && paddr == OFF_FLAGS
		|-> !(prdata[7] && prdata[5]) && !(prdata[6] && prdata[4])) else $error("Empty and full both set.");
	busy_on_write_a: assert property ((wr_acc && paddr == OFF_DATA)
		##2 (psel && !penable && !pwrite && paddr == OFF_FLAGS) |=> prdata[3]) else $error("Busy not set.");
	data_upper_a: assert property (rd_acc && paddr == OFF_DATA
		|-> prdata[31:12] == 20'h0) else $error("Data read upper bits set.");
	status_upper_a: assert property (rd_acc && paddr == OFF_RX_STATUS
		|-> prdata[31:4] == 28'h0) else $error("Status upper bits set.");
	status_hold_a: assert property (rd_acc && paddr == OFF_RX_STATUS && hold_ok_r
		|-> prdata[2:0] == hold_val_r) else $error("Status changed without data read.");
	clear_errs_a: assert property ((wr_acc && paddr == OFF_RX_STATUS)
		##2 (psel && !penable && !pwrite && paddr == OFF_RX_STATUS) |=> prdata[2:0] == 3'h0) else $error("Clear failed.");
	brk_read_c: cover property (rd_acc && paddr == OFF_DATA && prdata[10]);
	err_clear_c: cover property (wr_acc && paddr == OFF_RX_STATUS);
	tx_full_c: cover property (rd_acc && paddr == OFF_FLAGS && prdata[5]);
endmodule : uart_data_status_path_props
bind uart_data_status_path uart_data_status_path_props chk (.clk_sys(clk_sys), .srst(srst), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .rx_line(rx_line), .tx_line(tx_line), .phone_call_line_n(phone_call_line_n));

/* File: uart_data_status_path_test.sv */
// Self-checking bench of the serial port data and status path.
`timescale 1ns/1ps
module uart_data_status_path_test;
	import uart_pkg::*;
	localparam int DIV = 2;
	localparam int BIT_CYC = 16 * DIV;
	logic clk_sys;
	logic srst;
	logic psel;
	logic penable;
	logic pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic rx_line;
	logic tx_line;
	logic phone_call_line_n;
	logic [31:0] rv;
	logic ev;
	logic [7:0] b;
	logic nb;
	int miscompares;
	int n_compared;
	// Block under test and the far end of its lines.
	uart_data_status_path dut (.clk_sys(clk_sys), .srst(srst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rx_line(rx_line), .tx_line(tx_line), .phone_call_line_n(phone_call_line_n));
	remote_serial #(.BIT_CYC(BIT_CYC)) far (.clk_sys(clk_sys), .tx_line(tx_line), .rx_line(rx_line));
	// Clock.
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	// Compares one value.
	task automatic check(input string s, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", s, exp, seen);
		end
	endtask : check
	// Prints the verdict and ends the run.
	task automatic summarize();
		$display("compared %0d mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : summarize
	// One bus transfer: setup, access, answer taken at the edge that sees ready.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
		int n;
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk_sys);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1 && n < 8);
		rv = prdata;
		ev = pslverr;
		check("ready", {31'h0, pready}, 32'h1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task automatic rd(input string s, input logic [11:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		check(s, rv, x);
	endtask : rd
	// Reprograms the line only while the port is off, then enables it when asked.
	task automatic cfg(input logic [7:0] lcr, input logic en);
		wr(OFF_SER_CTRL, 32'h0000_0300);
		wr(OFF_BAUD_INT, 32'(DIV));
		wr(OFF_LINE_CTRL, {24'h0, lcr});
		wr(OFF_SER_CTRL, {22'h0, 2'b11, 7'h0, en});
	endtask : cfg
	task automatic t_reset();
		rd("flags", OFF_FLAGS, 32'h090);
		rd("status", OFF_RX_STATUS, 32'h0);
		rd("ctrl", OFF_SER_CTRL, 32'h300);
		rd("level", OFF_LEVEL_SEL, 32'h12);
		rd("unmapped", 12'h01C, 32'h0);
		check("slverr", {31'h0, ev}, 32'h1);
		phone_call_line_n <= 1'b0;
		repeat (8) @(posedge clk_sys);
		rd("ring", OFF_FLAGS, 32'h190);
		phone_call_line_n <= 1'b1;
		$display("test reset done");
	endtask : t_reset
	task automatic t_tx();
		cfg(8'h70, 1'b1);
		wr(OFF_DATA, 32'h1A5);
		apb(1'b0, OFF_FLAGS, 32'h0);
		check("busy", rv & 32'h8, 32'h8);
		fork
			far.get(b, nb);
			begin
				repeat (3 * BIT_CYC) @(posedge clk_sys);
				wr(OFF_SER_CTRL, 32'h0300);
			end
		join
		check("tx byte", {24'h0, b}, 32'hA5);
		check("tx stop", {31'h0, nb}, 32'h1);
		repeat (BIT_CYC + 8) @(posedge clk_sys);
		rd("idle", OFF_FLAGS, 32'h090);
		$display("test transmit done");
	endtask : t_tx
	task automatic t_parity();
		logic [1:0] k;
		for (int i = 0; i < 4; i++) begin
			k = 2'(i);
			cfg({k[1], 3'b111, 1'b0, k[0], 2'b10}, 1'b1);
			wr(OFF_DATA, 32'h03);
			far.get(b, nb);
			check("tx parity", {31'h0, nb}, {31'h0, ~k[0]});
			far.send(8'h03, 1'b1, k[0], 1'b1);
			repeat (8) @(posedge clk_sys);
			rd("rx parity", OFF_DATA, 32'h203);
			rd("status pe", OFF_RX_STATUS, 32'h2);
			wr(OFF_RX_STATUS, 32'(k));
			rd("cleared", OFF_RX_STATUS, 32'h0);
		end
		$display("test parity done");
	endtask : t_parity
	task automatic t_frame_break();
		cfg(8'h70, 1'b1);
		far.send(8'h5A, 1'b0, 1'b0, 1'b0);
		repeat (8) @(posedge clk_sys);
		rd("rx framing", OFF_DATA, 32'h15A);
		rd("status fe", OFF_RX_STATUS, 32'h1);
		far.hold_low(12 * BIT_CYC);
		repeat (BIT_CYC) @(posedge clk_sys);
		rd("status kept", OFF_RX_STATUS, 32'h1);
		rd("break char", OFF_DATA, 32'h500);
		rd("one char", OFF_FLAGS, 32'h090);
		rd("status be", OFF_RX_STATUS, 32'h5);
		far.send(8'h33, 1'b0, 1'b0, 1'b1);
		repeat (8) @(posedge clk_sys);
		rd("resumed", OFF_DATA, 32'h033);
		wr(OFF_RX_STATUS, 32'h0);
		$display("test framing and break done");
	endtask : t_frame_break
	task automatic t_overrun();
		cfg(8'h60, 1'b1);
		far.send(8'h11, 1'b0, 1'b0, 1'b1);
		repeat (8) @(posedge clk_sys);
		rd("hold full", OFF_FLAGS, 32'h0C0);
		far.send(8'h22, 1'b0, 1'b0, 1'b1);
		repeat (8) @(posedge clk_sys);
		rd("status oe", OFF_RX_STATUS, 32'h8);
		rd("kept char", OFF_DATA, 32'h011);
		far.send(8'h44, 1'b0, 1'b0, 1'b1);
		repeat (8) @(posedge clk_sys);
		rd("oe carried", OFF_DATA, 32'h844);
		wr(OFF_RX_STATUS, 32'h0);
		rd("oe cleared", OFF_RX_STATUS, 32'h0);
		$display("test overrun done");
	endtask : t_overrun
	task automatic t_fill();
		cfg(8'h70, 1'b0);
		for (int i = 0; i < 33; i++) begin
			wr(OFF_DATA, 32'(i + 64));
			if (i == 30) rd("almost full", OFF_FLAGS, 32'h018);
		end
		rd("tx full", OFF_FLAGS, 32'h038);
		wr(OFF_SER_CTRL, 32'h0301);
		for (int i = 0; i < 32; i++) begin
			far.get(b, nb);
			check("queued", {24'h0, b}, 32'(i + 64));
		end
		repeat (BIT_CYC + 8) @(posedge clk_sys);
		rd("drained", OFF_FLAGS, 32'h090);
		$display("test fill done");
	endtask : t_fill
	// Main sequence.
	initial begin
		srst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		phone_call_line_n = 1'b1;
		miscompares = 0;
		n_compared = 0;
		repeat (5) @(posedge clk_sys);
		srst <= 1'b0;
		t_reset();
		t_tx();
		t_parity();
		t_frame_break();
		t_overrun();
		t_fill();
		summarize();
	end
	// Watchdog against a hang.
	initial begin
		repeat (60000) @(posedge clk_sys);
		miscompares++;
		$display("watchdog expired");
		summarize();
	end
endmodule : uart_data_status_path_test

/* File: uart_pkg.sv */
// Shared constants and types for the serial port data and status path.
package uart_pkg;
	// Register offsets, byte addresses of the peripheral bus.
	localparam logic [11:0] OFF_DATA = 12'h000;
	localparam logic [11:0] OFF_RX_STATUS = 12'h004;
	localparam logic [11:0] OFF_FLAGS = 12'h018;
	localparam logic [11:0] OFF_LP_DIV = 12'h020;
	localparam logic [11:0] OFF_BAUD_INT = 12'h024;
	localparam logic [11:0] OFF_BAUD_FRAC = 12'h028;
	localparam logic [11:0] OFF_LINE_CTRL = 12'h02C;
	localparam logic [11:0] OFF_SER_CTRL = 12'h030;
	localparam logic [11:0] OFF_LEVEL_SEL = 12'h034;
	localparam logic [11:0] OFF_IRQ_MASK = 12'h038;
	localparam logic [11:0] OFF_RAW_IRQ = 12'h03C;
	localparam logic [11:0] OFF_MASKED_IRQ = 12'h040;
	localparam logic [11:0] OFF_IRQ_CLEAR = 12'h044;
	localparam logic [11:0] OFF_DMA_CTRL = 12'h048;
	// Buffer geometry.
	localparam int unsigned TX_W = 8;
	localparam int unsigned RX_W = 12;
	localparam int unsigned FIFO_DEPTH = 32;
	localparam int unsigned PTR_W = 5;
	localparam int unsigned CNT_W = 6;
	// Line control field positions.
	localparam int unsigned LCR_BRK = 0;
	localparam int unsigned LCR_PEN = 1;
	localparam int unsigned LCR_EPS = 2;
	localparam int unsigned LCR_STP2 = 3;
	localparam int unsigned LCR_FEN = 4;
	localparam int unsigned LCR_WLEN = 5;
	localparam int unsigned LCR_SPS = 7;
	// Serial control field positions.
	localparam int unsigned CR_UARTEN = 0;
	localparam int unsigned CR_TXE = 8;
	localparam int unsigned CR_RXE = 9;
	// Receive entry status positions.
	localparam int unsigned ENT_FE = 8;
	localparam int unsigned ENT_PE = 9;
	localparam int unsigned ENT_BE = 10;
	localparam int unsigned ENT_OE = 11;
	// Reset values.
	localparam logic [15:0] SER_CTRL_RST = 16'h0300;
	localparam logic [5:0] LEVEL_SEL_RST = 6'h12;
	localparam logic [7:0] LINE_CTRL_RST = 8'h00;
	localparam logic [15:0] BAUD_INT_RST = 16'h0000;
	// Oversampling: sixteen ticks per bit, start bit checked at its middle.
	localparam logic [3:0] TICK_LAST = 4'hF;
	localparam logic [3:0] TICK_MID = 4'h7;
	// Transmit and receive sequencer states.
	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} tx_state_t;
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_BRK_WAIT} rx_state_t;
endpackage : uart_pkg
